/* File: core/mmi_interp.sv */
// MIDI message interpreter with APB configuration and status registers.
`timescale 1ns/10ps
`include "mmi_cfg.svh"
module mmi_interp #(
  parameter int VOICES = 8,
  parameter int PERIOD_W = 20
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic reset_in,
  // APB slave
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // Received byte stream
  input wire logic [7:0] midi_byte_in,
  input wire logic midi_valid_in,
  // Voice events
  output logic voice_start_out,
  output logic voice_stop_out,
  output logic [$clog2(VOICES)-1:0] voice_idx_out,
  output logic [6:0] voice_note_out,
  output logic [6:0] voice_vel_out,
  output logic [7:0] voice_semis_out,
  output logic all_off_out,
  // Pressure, program and controller events
  output logic press_valid_out,
  output logic press_poly_out,
  output logic [6:0] press_note_out,
  output logic [6:0] press_val_out,
  output logic prog_valid_out,
  output logic [6:0] prog_num_out,
  output logic [3:0] prog_chan_out,
  output logic ctrl_valid_out,
  output logic [6:0] ctrl_num_out,
  output logic [13:0] ctrl_val_out,
  output logic ctrl_reset_out,
  output logic param_valid_out,
  output logic local_on_out,
  // Exclusive data and transport
  output logic syx_valid_out,
  output logic [6:0] syx_data_out,
  output logic running_out,
  output logic tick_out,
  output logic fine_tick_out
);
  localparam int IW = $clog2(VOICES);
  wire logic [7:0] b = midi_byte_in;
  logic [7:0] status_q;
  logic have1_q;
  logic [6:0] d1_q;
  mmi_pkg::mmi_sx_state_type sx_q;
  logic [3:0] base_q;
  logic omni_q, mono_q, local_q, running_q, param_reg_q;
  logic [4:0] mono_cnt_q;
  logic [6:0] syx_id_q, prog_q;
  logic [3:0] switch_q;
  logic [13:0] param_num_q, param_data_q, pos_q;
  logic [2:0] phase_q;
  logic [6:0] coarse_q [32];
  logic [6:0] vnote_q [VOICES];
  logic [VOICES-1:0] von_q;
  logic [PERIOD_W-1:0] period_q, gap_q, sub_left_q;
  logic [1:0] sub_idx_q;

  logic is_rt, is_stat, is_data, two, fire, acc, chan_ok;
  logic note_on, note_off, cc_fire;
  logic [3:0] kind, ch;
  logic [6:0] d1, d2;
  logic [4:0] ch_off, span;
  assign is_rt = midi_valid_in && (b[7:3] == 5'h1F);
  assign is_stat = midi_valid_in && b[7] && !is_rt;
  assign is_data = midi_valid_in && !b[7];
  assign kind = status_q[7:4];
  assign ch = status_q[3:0];
  assign two = (kind != `MMI_K_PROG) && (kind != `MMI_K_CHAN_PRESS);
  assign fire = is_data && status_q[7] && (have1_q || !two);
  assign d1 = two ? d1_q : b[6:0];
  assign d2 = b[6:0];
  assign ch_off = {1'b0, ch} - {1'b0, base_q};
  assign span = (mono_q && mono_cnt_q != 5'h00) ? mono_cnt_q : 5'h01;
  assign chan_ok = omni_q || (ch_off < span);
  assign acc = fire && (kind == `MMI_K_SYSTEM || chan_ok);
  assign note_on = acc && kind == `MMI_K_NOTE_ON && d2 != 7'h00;
  assign note_off = acc && (kind == `MMI_K_NOTE_OFF || (kind == `MMI_K_NOTE_ON && d2 == 7'h00));

  function automatic logic cc_known(input logic [6:0] n);
    cc_known = (n inside {[7'h01:7'h08], 7'h0A, 7'h0B, [7'h10:7'h13], [7'h20:7'h43],
      7'h45, [7'h50:7'h53], [7'h5C:7'h65], [7'h79:7'h7F]});
  endfunction
  assign cc_fire = acc && kind == `MMI_K_CTRL && cc_known(d1);

  // Running status survives real-time bytes; any other status cancels it.
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      status_q <= 8'h00;
      have1_q <= 1'b0;
      d1_q <= 7'h00;
    end
    else if (is_stat)
    begin
      status_q <= (b[7:4] != `MMI_K_SYSTEM || b == `MMI_B_SONG_POS) ? b : 8'h00;
      have1_q <= 1'b0;
    end
    else if (is_data && status_q[7])
    begin
      have1_q <= two && !have1_q;
      d1_q <= b[6:0];
    end
  end

  // The first data byte after the exclusive start is the maker code.
  always_ff @(posedge clock_in)
  begin
    syx_valid_out <= 1'b0;
    if (reset_in)
    begin
      sx_q <= mmi_pkg::SX_IDLE;
      syx_data_out <= 7'h00;
    end
    else if (is_stat)
      sx_q <= (b == `MMI_B_SYX_BEGIN) ? mmi_pkg::SX_ID : mmi_pkg::SX_IDLE;
    else if (is_data)
    begin
      unique case (sx_q)
        mmi_pkg::SX_ID: sx_q <= (b[6:0] == syx_id_q) ? mmi_pkg::SX_MINE : mmi_pkg::SX_SKIP;
        mmi_pkg::SX_MINE:
        begin
          syx_valid_out <= 1'b1;
          syx_data_out <= b[6:0];
        end
        mmi_pkg::SX_IDLE, mmi_pkg::SX_SKIP: sx_q <= sx_q;
      endcase
    end
  end

  logic free_hit, match_hit;
  logic [IW-1:0] free_idx, match_idx;
  always_comb
  begin
    free_hit = 1'b0;
    match_hit = 1'b0;
    free_idx = '0;
    match_idx = '0;
    for (int i = VOICES - 1; i >= 0; i--)
    begin
      if (!von_q[i])
      begin
        free_hit = 1'b1;
        free_idx = IW'(i);
      end
      if (von_q[i] && vnote_q[i] == d1)
      begin
        match_hit = 1'b1;
        match_idx = IW'(i);
      end
    end
  end

  logic silence;
  assign silence = cc_fire && d1 == `MMI_CC_NOTES_OFF && d2 == 7'h00;
  // Poly drops a note when every voice is busy rather than stealing one.
  always_ff @(posedge clock_in)
  begin
    voice_start_out <= 1'b0;
    voice_stop_out <= 1'b0;
    all_off_out <= 1'b0;
    if (reset_in)
    begin
      von_q <= '0;
      voice_idx_out <= '0;
      voice_note_out <= 7'h00;
      voice_vel_out <= 7'h00;
      voice_semis_out <= 8'h00;
      for (int i = 0; i < VOICES; i++)
        vnote_q[i] <= 7'h00;
    end
    else if (silence)
    begin
      von_q <= '0;
      all_off_out <= 1'b1;
    end
    else if (note_on && (mono_q || free_hit))
    begin
      voice_start_out <= 1'b1;
      voice_idx_out <= mono_q ? '0 : free_idx;
      voice_note_out <= d1;
      voice_vel_out <= d2;
      voice_semis_out <= {1'b0, d1} - `MMI_MIDDLE_C;
      von_q[mono_q ? 0 : free_idx] <= 1'b1;
      vnote_q[mono_q ? 0 : free_idx] <= d1;
    end
    else if (note_off && match_hit)
    begin
      voice_stop_out <= 1'b1;
      voice_idx_out <= match_idx;
      voice_note_out <= d1;
      von_q[match_idx] <= 1'b0;
    end
  end

  always_ff @(posedge clock_in)
  begin
    press_valid_out <= 1'b0;
    prog_valid_out <= 1'b0;
    if (reset_in)
    begin
      press_poly_out <= 1'b0;
      press_note_out <= 7'h00;
      press_val_out <= 7'h00;
      prog_q <= 7'h00;
      prog_chan_out <= 4'h0;
    end
    else if (acc && kind == `MMI_K_POLY_PRESS)
    begin
      press_valid_out <= 1'b1;
      press_poly_out <= 1'b1;
      press_note_out <= d1;
      press_val_out <= d2;
    end
    else if (acc && kind == `MMI_K_CHAN_PRESS)
    begin
      press_valid_out <= 1'b1;
      press_poly_out <= 1'b0;
      press_note_out <= 7'h00;
      press_val_out <= d1;
    end
    else if (acc && kind == `MMI_K_PROG)
    begin
      prog_valid_out <= 1'b1;
      prog_q <= d1;
      prog_chan_out <= ch;
    end
  end
  assign prog_num_out = prog_q;

  // Controllers and parameter entry.
  logic [13:0] param_next;
  always_comb
  begin
    param_next = param_data_q;
    if (d1 == `MMI_CC_DATA_MSB)
      param_next = {d2, 7'h00};
    else if (d1 == `MMI_CC_DATA_LSB)
      param_next = {param_data_q[13:7], d2};
    else if (d1 == `MMI_CC_INC && param_data_q != 14'h3FFF)
      param_next = param_data_q + 14'h0001;
    else if (d1 == `MMI_CC_DEC && param_data_q != 14'h0000)
      param_next = param_data_q - 14'h0001;
  end

  always_ff @(posedge clock_in)
  begin
    ctrl_valid_out <= 1'b0;
    ctrl_reset_out <= 1'b0;
    param_valid_out <= 1'b0;
    if (reset_in)
    begin
      ctrl_num_out <= 7'h00;
      ctrl_val_out <= 14'h0000;
      switch_q <= 4'h0;
      param_num_q <= `MMI_PARAM_NULL;
      param_data_q <= 14'h0000;
      param_reg_q <= 1'b1;
      for (int i = 0; i < 32; i++)
        coarse_q[i] <= 7'h00;
    end
    else if (cc_fire && d1 == `MMI_CC_RESET_ALL && d2 == 7'h00)
    begin
      ctrl_reset_out <= 1'b1;
      switch_q <= 4'h0;
      param_num_q <= `MMI_PARAM_NULL;
      for (int i = 0; i < 32; i++)
        coarse_q[i] <= 7'h00;
    end
    else if (cc_fire && d1 < `MMI_CC_RESET_ALL)
    begin
      ctrl_valid_out <= 1'b1;
      ctrl_num_out <= d1;
      ctrl_val_out <= {d2, 7'h00};
      if (d1 < `MMI_CC_FINE_LO)
        coarse_q[d1[4:0]] <= d2;
      else if (d1 <= `MMI_CC_FINE_HI)
      begin
        ctrl_num_out <= d1 - `MMI_CC_FINE_LO;
        ctrl_val_out <= {coarse_q[d1[4:0]], d2};
      end
      if (d1 >= `MMI_CC_SUSTAIN && d1 <= `MMI_CC_SOFT)
        switch_q[d1[1:0]] <= d2[6];
      if (d1 inside {`MMI_CC_RPN_MSB, `MMI_CC_NRPN_MSB})
      begin
        param_num_q[13:7] <= d2;
        param_reg_q <= d1 == `MMI_CC_RPN_MSB;
      end
      if (d1 inside {`MMI_CC_RPN_LSB, `MMI_CC_NRPN_LSB})
      begin
        param_num_q[6:0] <= d2;
        param_reg_q <= d1 == `MMI_CC_RPN_LSB;
      end
      if (d1 inside {`MMI_CC_DATA_MSB, `MMI_CC_DATA_LSB, `MMI_CC_INC, `MMI_CC_DEC}
          && param_num_q != `MMI_PARAM_NULL)
      begin
        param_data_q <= param_next;
        param_valid_out <= 1'b1;
      end
    end
  end

  // Mode state: software sets it over APB, mode messages arriving later override it.
  logic apb_wr;
  assign apb_wr = psel_in && penable_in && pwrite_in;
  always_ff @(posedge clock_in)
  begin
    if (reset_in)
    begin
      base_q <= `MMI_RST_BASE_CH;
      omni_q <= 1'b0;
      mono_q <= 1'b0;
      mono_cnt_q <= `MMI_RST_MONO_CNT;
      syx_id_q <= `MMI_RST_SYX_ID;
      local_q <= 1'b1;
    end
    else
    begin
      if (apb_wr && paddr_in == `MMI_OFS_CFG)
      begin
        base_q <= pwdata_in[3:0];
        omni_q <= pwdata_in[4];
        mono_q <= pwdata_in[5];
        mono_cnt_q <= pwdata_in[10:6];
      end
      if (apb_wr && paddr_in == `MMI_OFS_SYX_ID)
        syx_id_q <= pwdata_in[6:0];
      if (cc_fire)
      begin
        unique case (d1)
          `MMI_CC_LOCAL: if (d2 == 7'h00 || d2 == 7'h7F) local_q <= d2[6];
          `MMI_CC_OMNI_OFF: omni_q <= 1'b0;
          `MMI_CC_OMNI_ON: omni_q <= 1'b1;
          `MMI_CC_MONO:
          begin
            mono_q <= 1'b1;
            mono_cnt_q <= (d2 > 7'h10) ? 5'h10 : d2[4:0];
            if (d2 == 7'h00)
              omni_q <= 1'b0;
          end
          `MMI_CC_POLY: mono_q <= 1'b0;
          default: ;
        endcase
      end
    end
  end
  assign local_on_out = local_q;

  // Transport: position counts sixteenths, six clocks each.
  logic rt_clock, rt_start, rt_stop, rt_cont, spp_fire;
  assign rt_clock = is_rt && b == `MMI_B_CLOCK;
  assign rt_start = is_rt && b == `MMI_B_START;
  assign rt_stop = is_rt && b == `MMI_B_STOP;
  assign rt_cont = is_rt && b == `MMI_B_CONT;
  assign spp_fire = acc && status_q == `MMI_B_SONG_POS;
  always_ff @(posedge clock_in)
  begin
    tick_out <= 1'b0;
    if (reset_in)
    begin
      running_q <= 1'b0;
      pos_q <= 14'h0000;
      phase_q <= 3'h0;
    end
    else if (rt_start)
    begin
      running_q <= 1'b1;
      pos_q <= 14'h0000;
      phase_q <= 3'h0;
    end
    else if (rt_stop)
      running_q <= 1'b0;
    else if (rt_cont)
      running_q <= 1'b1;
    else if (spp_fire)
    begin
      pos_q <= {d2, d1};
      phase_q <= 3'h0;
    end
    else if (rt_clock && running_q)
    begin
      tick_out <= 1'b1;
      phase_q <= (phase_q == `MMI_CLK_PER_STEP_M1) ? 3'h0 : phase_q + 3'h1;
      if (phase_q == `MMI_CLK_PER_STEP_M1)
        pos_q <= pos_q + 14'h0001;
    end
  end
  assign running_out = running_q;

  // Fine ticks split the last measured clock gap in four; a new clock re-locks them.
  always_ff @(posedge clock_in)
  begin
    fine_tick_out <= 1'b0;
    if (reset_in)
    begin
      gap_q <= '0;
      period_q <= '0;
      sub_left_q <= '0;
      sub_idx_q <= `MMI_SUB_PER_CLK_M1;
    end
    else if (rt_clock)
    begin
      gap_q <= '0;
      period_q <= gap_q;
      sub_left_q <= gap_q >> 2;
      sub_idx_q <= 2'h0;
      fine_tick_out <= running_q;
    end
    else
    begin
      if (gap_q != '1)
        gap_q <= gap_q + 1'b1;
      if (sub_idx_q != `MMI_SUB_PER_CLK_M1)
      begin
        if (sub_left_q == '0)
        begin
          fine_tick_out <= running_q;
          sub_left_q <= period_q >> 2;
          sub_idx_q <= sub_idx_q + 2'h1;
        end
        else
          sub_left_q <= sub_left_q - 1'b1;
      end
    end
  end

  // APB read side answers in the access cycle with no wait states.
  assign pready_out = 1'b1;
  logic mapped;
  assign mapped = paddr_in inside {`MMI_OFS_CFG, `MMI_OFS_SYX_ID, `MMI_OFS_STATUS,
    `MMI_OFS_POS, `MMI_OFS_PROG, `MMI_OFS_PARAM};
  assign pslverr_out = psel_in && penable_in && !mapped;
  always_comb
  begin
    prdata_out = 32'h0000_0000;
    if (psel_in && !pwrite_in)
    begin
      unique case (paddr_in)
        `MMI_OFS_CFG: prdata_out = {21'h0, mono_cnt_q, mono_q, omni_q, base_q};
        `MMI_OFS_SYX_ID: prdata_out = {25'h0, syx_id_q};
        `MMI_OFS_STATUS: prdata_out = {25'h0, switch_q, param_reg_q, local_q, running_q};
        `MMI_OFS_POS: prdata_out = {13'h0, phase_q, 2'h0, pos_q};
        `MMI_OFS_PROG: prdata_out = {25'h0, prog_q};
        `MMI_OFS_PARAM: prdata_out = {4'h0, param_data_q, param_num_q};
        default: prdata_out = 32'h0000_0000;
      endcase
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (reset_in);
  a_chan_reject: assert property (acc == 1'b0 && fire && kind == `MMI_K_NOTE_ON |=> !voice_start_out) else $error("note on accepted on foreign channel");
  a_omni_any: assert property (omni_q && note_on && free_hit && !silence |=> voice_start_out) else $error("omni note dropped");
  a_mono_voice: assert property (mono_q && note_on |=> voice_start_out && voice_idx_out == '0) else $error("mono used other voice");
  a_vel_zero: assert property (acc && kind == `MMI_K_NOTE_ON && d2 == 7'h00 |=> !voice_start_out) else $error("zero velocity started voice");
  a_notes_off: assert property (silence |=> von_q == '0 && all_off_out) else $error("voices survive all notes off");
  a_prog_take: assert property (acc && kind == `MMI_K_PROG |=> prog_valid_out && prog_num_out == $past(b[6:0])) else $error("program not taken");
  a_fine_join: assert property (cc_fire && d1 >= `MMI_CC_FINE_LO && d1 <= `MMI_CC_FINE_HI |=> ctrl_val_out[6:0] == $past(b[6:0]) && ctrl_num_out < `MMI_CC_FINE_LO) else $error("fine controller not joined");
  a_start_home: assert property (rt_start |=> running_q && pos_q == 14'h0000 && phase_q == 3'h0) else $error("start did not rewind");
  a_stop_hold: assert property (rt_stop |=> !running_q && $stable(pos_q)) else $error("stop moved position");
  a_local_sw: assert property (cc_fire && d1 == `MMI_CC_LOCAL && d2 == 7'h7F |=> local_on_out) else $error("local on ignored");
  c_note_start: cover property (note_on ##1 voice_start_out);
  c_syx_mine: cover property (syx_valid_out);
  c_resume: cover property (rt_stop ##[1:20] rt_cont);
  c_fine_tick: cover property (fine_tick_out && !rt_clock);
endmodule // mmi_interp

/* File: inc/mmi_cfg.svh */
// Constants for the MIDI message interpreter.
// Behaviour
// - With omni on accept channel messages on any channel, otherwise only selected channels.
// - Mono assignment sounds one note at a time; poly uses every free voice.
// - Note numbers run 0 to 127 with middle C at 60, mapped to pitch.
// - Note off ends the matching sounding note, same number range as note on.
// - Velocity 1 to 127 scales dynamics; velocity zero acts as note off.
// - Channel pressure is one value for all keys; poly pressure is per key.
// - Program change selects one of 128 programs on the addressed channel.
// - Controller numbers are decoded by function, such as 1, 7 and 10.
// - Controllers 32 to 63 are fine halves of controllers 0 to 31.
// - Switch controllers 64 to 67 take 0 for off and 127 for on.
// - Controllers 98 to 101 pick a parameter number; entry, 96 and 97 modify it.
// - Controller 121 resets all controllers; 123 silences every note on the channel.
// - Controller 122 with 0 or 127 switches local control off or on.
// - 124 and 125 set omni off and on; 126 mono with count; 127 poly.
// - System messages act regardless of channel or omni setting.
// - Song position gives sixteenth beats from start; playback relocates there.
// - Exclusive data is used only when addressed to this maker's equipment.
// - Each timing clock advances by one twenty-fourth of a quarter note.
// - The received clock is subdivided to 96 pulses per quarter note, locked.
// - Start always begins playback from the beginning of the song.
// - Stop halts and keeps position; continue resumes from there.
`ifndef MMI_CFG_SVH
`define MMI_CFG_SVH
`define MMI_K_NOTE_OFF 4'h8
`define MMI_K_NOTE_ON 4'h9
`define MMI_K_POLY_PRESS 4'hA
`define MMI_K_CTRL 4'hB
`define MMI_K_PROG 4'hC
`define MMI_K_CHAN_PRESS 4'hD
`define MMI_K_SYSTEM 4'hF
`define MMI_B_SYX_BEGIN 8'hF0
`define MMI_B_SONG_POS 8'hF2
`define MMI_B_CLOCK 8'hF8
`define MMI_B_START 8'hFA
`define MMI_B_CONT 8'hFB
`define MMI_B_STOP 8'hFC
`define MMI_CC_DATA_MSB 7'h06
`define MMI_CC_FINE_LO 7'h20
`define MMI_CC_FINE_HI 7'h3F
`define MMI_CC_SUSTAIN 7'h40
`define MMI_CC_SOFT 7'h43
`define MMI_CC_DATA_LSB 7'h26
`define MMI_CC_INC 7'h60
`define MMI_CC_DEC 7'h61
`define MMI_CC_NRPN_MSB 7'h62
`define MMI_CC_NRPN_LSB 7'h63
`define MMI_CC_RPN_MSB 7'h64
`define MMI_CC_RPN_LSB 7'h65
`define MMI_CC_RESET_ALL 7'h79
`define MMI_CC_LOCAL 7'h7A
`define MMI_CC_NOTES_OFF 7'h7B
`define MMI_CC_OMNI_OFF 7'h7C
`define MMI_CC_OMNI_ON 7'h7D
`define MMI_CC_MONO 7'h7E
`define MMI_CC_POLY 7'h7F
`define MMI_MIDDLE_C 8'h3C
`define MMI_CLK_PER_STEP_M1 3'h5
`define MMI_SUB_PER_CLK_M1 2'h3
`define MMI_PARAM_NULL 14'h3FFF
`define MMI_OFS_CFG 8'h00
`define MMI_OFS_SYX_ID 8'h04
`define MMI_OFS_STATUS 8'h08
`define MMI_OFS_POS 8'h0C
`define MMI_OFS_PROG 8'h10
`define MMI_OFS_PARAM 8'h14
`define MMI_RST_BASE_CH 4'h0
`define MMI_RST_MONO_CNT 5'h01
// The default maker code is arbitrary; software sets the real one.
`define MMI_RST_SYX_ID 7'h7D
`endif

/* File: inc/mmi_pkg.sv */
// Types for the MIDI message interpreter.
package mmi_pkg;
  typedef enum logic [1:0] {SX_IDLE, SX_ID, SX_MINE, SX_SKIP} mmi_sx_state_type;
endpackage

/* File: sim/mmi_midi_src.sv */
// Behavioural sequencer that feeds received bytes to the interpreter.
`timescale 1ns/10ps
module mmi_midi_src (
  // Clock
  input wire logic clock_in,
  // Byte stream
  output logic [7:0] byte_out,
  output logic valid_out
);
  initial
  begin
    byte_out = 8'h00;
    valid_out = 1'b0;
  end
  // The byte line is inverted between bytes so that stale data never looks fresh.
  task send(input logic [7:0] b);
    @(posedge clock_in);
    byte_out <= b;
    valid_out <= 1'b1;
    @(posedge clock_in);
    valid_out <= 1'b0;
    byte_out <= ~b;
  endtask
  // Note and velocity bytes keep the top bit clear, so numbers stay in 0 to 127.
  task note(input logic [7:0] st, input logic [6:0] n, input logic [6:0] v);
    send(st);
    send({1'b0, n});
    send({1'b0, v});
  endtask
  // The low seven bits of the position go first.
  task song_pos(input logic [13:0] p);
    send(8'hF2);
    send({1'b0, p[6:0]});
    send({1'b0, p[13:7]});
  endtask
  // Clocks at a steady gap; 24 of them make a quarter note.
  task clocks(input int n, input int gap);
    repeat (n)
    begin
      send(8'hF8);
      repeat (gap) @(posedge clock_in);
    end
  endtask
endmodule // mmi_midi_src

/* File: sim/midi_message_interpreter_tb.sv */
// Self-checking bench for the MIDI message interpreter.
`timescale 1ns/10ps
module midi_message_interpreter_tb;
  logic clock_in = 1'b0, reset_in = 1'b1, psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h00, midi_byte_in;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rdat;
  logic pready_out, pslverr_out, midi_valid_in, voice_start_out, voice_stop_out, all_off_out;
  logic [2:0] voice_idx_out;
  logic [6:0] voice_note_out, voice_vel_out, press_note_out, press_val_out, prog_num_out;
  logic [7:0] voice_semis_out;
  logic [6:0] ctrl_num_out, syx_data_out;
  logic [3:0] prog_chan_out;
  logic [13:0] ctrl_val_out;
  logic press_valid_out, press_poly_out, prog_valid_out, ctrl_valid_out, ctrl_reset_out;
  logic param_valid_out, local_on_out, syx_valid_out, running_out, tick_out, fine_tick_out;
  logic rerr;
  int failures = 0, checks_done = 0, k;
  int c[11] = '{default: 0};
  int b[11];
  wire [10:0] pl = {voice_start_out, voice_stop_out, all_off_out, press_valid_out,
    prog_valid_out, ctrl_valid_out, ctrl_reset_out, param_valid_out, syx_valid_out,
    tick_out, fine_tick_out};

  mmi_interp #(.VOICES(8), .PERIOD_W(20)) i_dut (.clock_in, .reset_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .midi_byte_in,
    .midi_valid_in, .voice_start_out, .voice_stop_out, .voice_idx_out, .voice_note_out,
    .voice_vel_out, .voice_semis_out, .all_off_out, .press_valid_out, .press_poly_out,
    .press_note_out, .press_val_out, .prog_valid_out, .prog_num_out, .prog_chan_out,
    .ctrl_valid_out, .ctrl_num_out, .ctrl_val_out, .ctrl_reset_out, .param_valid_out,
    .local_on_out, .syx_valid_out, .syx_data_out, .running_out, .tick_out, .fine_tick_out);
  mmi_midi_src src (.clock_in, .byte_out(midi_byte_in), .valid_out(midi_valid_in));

  always #50 clock_in = ~clock_in;

  // Pulses are counted rather than caught, so a one-cycle event is never missed.
  always @(posedge clock_in)
  begin
    for (int i = 0; i < 11; i++)
      if (pl[i] === 1'b1)
        c[i] <= c[i] + 1;
  end

  task stop_test;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    for (k = 0; k < 16; k++)
    begin
      @(posedge clock_in);
      if (pready_out === 1'b1)
        break;
    end
    if (k == 16)
    begin
      failures++;
      stop_test();
    end
    else
    begin
      rdat = prdata_out;
      rerr = pslverr_out;
      psel_in <= 1'b0;
      penable_in <= 1'b0;
    end
  endtask

  task rd(input logic [7:0] a);
    xfer(1'b0, a, 32'h0000_0000);
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    xfer(1'b1, a, d);
  endtask

  task tx(input logic [7:0] x, input logic [7:0] y, input logic [7:0] z, input int n);
    src.send(x);
    if (n > 1)
      src.send(y);
    if (n > 2)
      src.send(z);
    repeat (3) @(posedge clock_in);
  endtask

  function automatic int dc(input int i);
    return c[i] - b[i];
  endfunction

  initial
  begin
    repeat (20) @(posedge clock_in);
    reset_in <= 1'b0;
    rd(8'h00);
    chk("cfg", rdat, 32'h0000_0040);
    rd(8'h18);
    chk("unmapped", {rdat[30:0], rerr}, 32'h1);
    b = c;
    src.note(8'h90, 7'h3C, 7'h40);
    tx(8'h91, 8'h40, 8'h10, 3);
    chk("start", dc(10), 1);
    chk("semis", voice_semis_out, 8'h00);
    chk("note", voice_note_out, 7'h3C);
    chk("vel", voice_vel_out, 7'h40);
    tx(8'hB0, 8'h7D, 8'h00, 3);
    src.note(8'h91, 7'h40, 7'h10);
    tx(8'h90, 8'h3C, 8'h00, 3);
    chk("start2", dc(10), 2);
    chk("stop vel0", dc(9), 1);
    tx(8'h81, 8'h40, 8'h00, 3);
    tx(8'h80, 8'h22, 8'h00, 3);
    chk("stop off", dc(9), 2);
    tx(8'hB0, 8'h07, 8'h64, 3);
    chk("ctl num", ctrl_num_out, 7'h07);
    tx(8'hB0, 8'h27, 8'h05, 3);
    chk("ctl fine", {ctrl_num_out, ctrl_val_out}, {7'h07, 14'h3205});
    tx(8'hB0, 8'h09, 8'h11, 3);
    chk("ctl cnt", dc(5), 2);
    tx(8'hB0, 8'h40, 8'h7F, 3);
    rd(8'h08);
    chk("sustain", rdat[3], 1'b1);
    tx(8'hB0, 8'h7A, 8'h00, 3);
    chk("local off", local_on_out, 1'b0);
    tx(8'hB0, 8'h7A, 8'h7F, 3);
    chk("local on", local_on_out, 1'b1);
    tx(8'hB0, 8'h79, 8'h00, 3);
    tx(8'hB0, 8'h7B, 8'h00, 3);
    rd(8'h08);
    chk("reset all", dc(4), 1);
    chk("all off", dc(8), 1);
    chk("switch clr", rdat[3], 1'b0);
    tx(8'hB0, 8'h64, 8'h00, 3);
    tx(8'hB0, 8'h65, 8'h00, 3);
    tx(8'hB0, 8'h06, 8'h02, 3);
    tx(8'hB0, 8'h60, 8'h7F, 3);
    chk("param", dc(3), 2);
    tx(8'hC3, 8'h05, 8'h00, 2);
    chk("prog", {prog_chan_out, prog_num_out}, {4'h3, 7'h05});
    chk("prog cnt", dc(6), 1);
    tx(8'hD0, 8'h20, 8'h00, 2);
    chk("chan press", {press_poly_out, press_val_out}, {1'b0, 7'h20});
    tx(8'hA0, 8'h3C, 8'h11, 3);
    chk("poly press", {press_poly_out, press_note_out}, {1'b1, 7'h3C});
    chk("press cnt", dc(7), 2);
    tx(8'hB0, 8'h7C, 8'h00, 3);
    tx(8'hB0, 8'h7E, 8'h01, 3);
    rd(8'h00);
    chk("mono cfg", rdat[10:4], 7'h06);
    b = c;
    src.note(8'h90, 7'h30, 7'h40);
    tx(8'h90, 8'h32, 8'h40, 3);
    chk("mono starts", dc(10), 2);
    chk("mono stops", dc(9), 0);
    chk("mono voice", voice_idx_out, 3'h0);
    tx(8'hB0, 8'h7F, 8'h00, 3);
    rd(8'h00);
    chk("poly cfg", rdat[5], 1'b0);
    tx(8'hF0, 8'h7D, 8'h01, 3);
    tx(8'h02, 8'hF7, 8'h00, 2);
    tx(8'hF0, 8'h11, 8'h03, 3);
    tx(8'hF7, 8'h00, 8'h00, 1);
    chk("sysex cnt", dc(2), 2);
    chk("sysex data", syx_data_out, 7'h02);
    tx(8'hFA, 8'h00, 8'h00, 1);
    chk("run", running_out, 1'b1);
    src.clocks(6, 14);
    rd(8'h0C);
    chk("ticks", dc(1), 6);
    chk("pos", rdat[13:0], 14'h0001);
    tx(8'hFC, 8'h00, 8'h00, 1);
    chk("halt", running_out, 1'b0);
    tx(8'hFB, 8'h00, 8'h00, 1);
    rd(8'h0C);
    chk("resume", {running_out, rdat[13:0]}, {1'b1, 14'h1});
    src.song_pos(14'h5);
    repeat (3) @(posedge clock_in);
    rd(8'h0C);
    chk("song pos", rdat[13:0], 14'h5);
    src.clocks(3, 14);
    b = c;
    src.clocks(3, 14);
    chk("fine", dc(0), 12);
    tx(8'hFA, 8'h00, 8'h00, 1);
    rd(8'h0C);
    chk("restart", rdat[13:0], 14'h0);
    wr(8'h00, 32'h0000_0045);
    wr(8'h04, 32'h0000_0011);
    rd(8'h00);
    chk("cfg wr", rdat, 32'h0000_0045);
    b = c;
    src.note(8'h95, 8'h40, 8'h20);
    tx(8'h90, 8'h41, 8'h20, 3);
    chk("base ch", dc(10), 1);
    chk("base note", voice_note_out, 7'h40);
    tx(8'hF0, 8'h11, 8'h22, 3);
    tx(8'hF7, 8'h00, 8'h00, 1);
    chk("id cnt", dc(2), 1);
    chk("id data", syx_data_out, 7'h22);
    stop_test();
  end

  initial
  begin
    #(100 * 90000);
    failures++;
    stop_test();
  end
endmodule // midi_message_interpreter_tb
